//--- cdc_checker.sv
/*
 * Port-level assertions for the clock distribution configuration block.
 * Assumes one clock domain and binding to cdc_clock_config below.
 */
`timescale 1ns/100ps

module cdc_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sen_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  input wire logic o_sdio,
  input wire logic o_sdio_oe_n,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_out_oe_n,
  input wire cdc_pkg::cdc_route_t o_route
);
  // ==========================================================
  // Routing outputs
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_route_reset;
    $rose(i_nrst) |-> (o_route == '0);
  endproperty
  a_route_reset: assert property (p_route_reset)
    else $error("routing not cleared by reset");
  property p_rx_src;
    o_route.rx_src_pll == o_route.alt_timing;
  endproperty
  a_rx_src: assert property (p_rx_src)
    else $error("rx source does not follow timing mode");
  property p_adc_src;
    o_route.adc_src_pll == o_route.alt_timing;
  endproperty
  a_adc_src: assert property (p_adc_src)
    else $error("adc source does not follow timing mode");
  property p_mult_legal;
    o_route.pll_mult <= 3'h4;
  endproperty
  a_mult_legal: assert property (p_mult_legal)
    else $error("unused multiplier code reached the loop");
  // Nothing may commit once the select has stayed released
  property p_route_quiet;
    i_sen_n [*6] |-> $stable(o_route);
  endproperty
  a_route_quiet: assert property (p_route_quiet)
    else $error("routing changed outside a frame");

  // ==========================================================
  // Serial output pins
  property p_oe_idle;
    i_sen_n [*5] |-> (o_sdio_oe_n && o_serial_data_out_oe_n);
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pin driven while deselected");
  property p_oe_excl;
    !(!o_sdio_oe_n && !o_serial_data_out_oe_n);
  endproperty
  a_oe_excl: assert property (p_oe_excl)
    else $error("both data pins driven");
  property p_data_same;
    (!o_sdio_oe_n || !o_serial_data_out_oe_n) |->
      (o_sdio == o_serial_data_out);
  endproperty
  a_data_same: assert property (p_data_same)
    else $error("output pins disagree");
  // Output bits move only in the low phase after a falling edge
  property p_data_edge;
    $changed(o_serial_data_out) |-> !i_sclk;
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("output bit changed while serial clock high");
endmodule // cdc_checker

bind cdc_clock_config cdc_checker u_cdc_checker (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_sen_n(i_sen_n), .i_sclk(i_sclk), .i_sdio(i_sdio),
  .o_sdio(o_sdio), .o_sdio_oe_n(o_sdio_oe_n),
  .o_serial_data_out(o_serial_data_out),
  .o_serial_data_out_oe_n(o_serial_data_out_oe_n), .o_route(o_route));

//--- cdc_clock_config.sv
/*
 * Serial register port and clock distribution configuration registers.
 * Assumes serial pins arrive asynchronously; serial clock must stay at
 * or below a quarter of i_clk so each level is seen after sync.
 */
// Behaviour
// - Bypass bit routes clock around the PLL while the PLL keeps running.
// - ADC clock halve bit divides the ADC source by two, default undivided.
// - ADC source is rx reference in normal timing, PLL out in alternate.
// - Alternate timing bit defaults low; high drives rx path from PLL.
// - Divide-by-five bit divides PLL output by five, default undivided.
// - Three-bit multiplier selects 1x,2x,4x,8x,16x; default 000.
// - Aux clock from PLL only when mode bit or full duplex is set.
// - Narrow bit changes the PLL loop bandwidth.
// - Port supports one or two byte transfers, MSB or LSB first.
// - Port is three-wire bidirectional or four-wire split data.
// - Normal timing tx from tx ref via PLL; alternate PLL clocks both.
// - Writes commit after the 16th or 24th rising edge; partial ignored.
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_clock_config (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sen_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe_n,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe_n,
  output cdc_pkg::cdc_route_t o_route
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sen_s_r;
  logic [1:0] sclk_s_r;
  logic [1:0] sdio_s_r;
  logic sclk_d_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sen_s_r <= 2'h3;
      sclk_s_r <= 2'h0;
      sdio_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sen_s_r <= {sen_s_r[0], i_sen_n};
      sclk_s_r <= {sclk_s_r[0], i_sclk};
      sdio_s_r <= {sdio_s_r[0], i_sdio};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  wire logic active = ~sen_s_r[1];
  wire logic rise = active & sclk_s_r[1] & ~sclk_d_r;
  wire logic fall = active & ~sclk_s_r[1] & sclk_d_r;
  wire logic din = sdio_s_r[1];

  // ==========================================================
  // Register storage
  logic [7:0] port_cfg_r;
  logic [7:0] mode_r;
  logic [7:0] io_cfg_r;
  logic [7:0] pll_clk_r;
  logic [7:0] route_r;

  wire logic lsb_first = port_cfg_r[`CDC_BIT_LSB_FIRST];
  wire logic three_wire = port_cfg_r[`CDC_BIT_THREE_WIRE];

  // Read mux, used for both bytes of a read
  function automatic logic [7:0] reg_read(input logic [5:0] a);
    case (a)
      `CDC_ADDR_PORT_CFG: reg_read = port_cfg_r;
      `CDC_ADDR_MODE: reg_read = mode_r;
      `CDC_ADDR_IO_CFG: reg_read = io_cfg_r;
      `CDC_ADDR_PLL_CLK: reg_read = pll_clk_r;
      `CDC_ADDR_ROUTE: reg_read = route_r;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Serial frame state
  logic [4:0] cnt_r;
  logic [7:0] in_sr_r;
  logic [7:0] out_sr_r;
  logic [7:0] byte0_r;
  logic done_r;
  cdc_pkg::cdc_instr_t instr_r;

  // Bit order follows the LSB-first setting for all bytes
  wire logic [7:0] in_nxt = lsb_first ? {din, in_sr_r[7:1]} :
                                        {in_sr_r[6:0], din};
  wire cdc_pkg::cdc_instr_t instr_nxt = in_nxt;
  // Second byte address walks down MSB-first, up LSB-first
  wire logic [5:0] addr2 = lsb_first ? instr_r.addr + 6'h01 :
                                       instr_r.addr - 6'h01;
  wire logic at_instr = rise & ~done_r & (cnt_r == `CDC_EDGE_INSTR);
  wire logic at_b1 = rise & ~done_r & (cnt_r == `CDC_EDGE_BYTE1);
  wire logic at_b2 = rise & ~done_r & (cnt_r == `CDC_EDGE_BYTE2);
  wire logic in_data = cnt_r > `CDC_EDGE_INSTR;
  wire logic rd_phase = active & in_data & instr_r.rd & ~done_r;

  // Commit only on the final edge of a complete write frame
  wire logic wr_single = at_b1 & ~instr_r.rd & ~instr_r.dual;
  wire logic wr_dual = at_b2 & ~instr_r.rd & instr_r.dual;
  wire logic wa_en = wr_single | wr_dual;
  wire logic [7:0] wa_data = instr_r.dual ? byte0_r : in_nxt;
  wire logic wb_en = wr_dual;

  // Frame counter restarts whenever the select goes high
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= 5'h00;
      done_r <= 1'b0;
    end else if (!active) begin
      cnt_r <= 5'h00;
      done_r <= 1'b0;
    end else if (rise && !done_r) begin
      cnt_r <= cnt_r + 5'h01;
      done_r <= (at_b1 & ~instr_r.dual) | at_b2;
    end
  end

  // Input shifter, instruction and first data byte hold
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_sr_r <= 8'h00;
      instr_r <= '0;
      byte0_r <= 8'h00;
    end else if (rise) begin
      in_sr_r <= in_nxt;
      if (at_instr) instr_r <= instr_nxt;
      if (at_b1) byte0_r <= in_nxt;
    end
  end

  // Read shifter loads at byte boundaries, shifts on falling edges
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_sr_r <= 8'h00;
    end else if (at_instr && instr_nxt.rd) begin
      out_sr_r <= reg_read(instr_nxt.addr);
    end else if (at_b1 && instr_r.rd && instr_r.dual) begin
      out_sr_r <= reg_read(addr2);
    end else if (fall && rd_phase) begin
      out_sr_r <= lsb_first ? {1'b0, out_sr_r[7:1]} :
                              {out_sr_r[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Output pins: one data bit per falling edge, float when deselected
  wire logic obit = lsb_first ? out_sr_r[0] : out_sr_r[7];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sdio <= 1'b0;
      o_serial_data_out <= 1'b0;
      o_sdio_oe_n <= 1'b1;
      o_serial_data_out_oe_n <= 1'b1;
    end else begin
      if (fall && rd_phase) begin
        o_sdio <= obit;
        o_serial_data_out <= obit;
      end
      // Three-wire turns data pin round and floats split output
      o_sdio_oe_n <= ~(rd_phase & three_wire &
                       (fall | ~o_sdio_oe_n));
      o_serial_data_out_oe_n <= ~(rd_phase & ~three_wire &
                                  (fall | ~o_serial_data_out_oe_n));
    end
  end

  // ==========================================================
  // Register writes; second byte of a dual write lands at addr2
  function automatic logic hit(input logic en, input logic [5:0] a,
                               input logic [5:0] r);
    hit = en & (a == r);
  endfunction

  wire logic [5:0] wa_addr = instr_r.addr;
  wire logic [7:0] wb_data = in_nxt;

  // Multiplier field keeps its old value on unused codes
  function automatic logic [7:0] pll_merge(input logic [7:0] d,
                                           input logic [7:0] old);
    pll_merge = (d[2:0] > `CDC_MULT_MAX) ? {d[7:3], old[2:0]} : d;
  endfunction

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      port_cfg_r <= `CDC_RST_PORT_CFG;
      mode_r <= `CDC_RST_MODE;
      io_cfg_r <= `CDC_RST_IO_CFG;
      pll_clk_r <= `CDC_RST_PLL_CLK;
      route_r <= `CDC_RST_ROUTE;
    end else begin
      if (hit(wa_en, wa_addr, `CDC_ADDR_PORT_CFG)) port_cfg_r <= wa_data;
      else if (hit(wb_en, addr2, `CDC_ADDR_PORT_CFG)) port_cfg_r <= wb_data;
      if (hit(wa_en, wa_addr, `CDC_ADDR_MODE)) mode_r <= wa_data;
      else if (hit(wb_en, addr2, `CDC_ADDR_MODE)) mode_r <= wb_data;
      if (hit(wa_en, wa_addr, `CDC_ADDR_IO_CFG)) io_cfg_r <= wa_data;
      else if (hit(wb_en, addr2, `CDC_ADDR_IO_CFG)) io_cfg_r <= wb_data;
      if (hit(wa_en, wa_addr, `CDC_ADDR_PLL_CLK))
        pll_clk_r <= pll_merge(wa_data, pll_clk_r);
      else if (hit(wb_en, addr2, `CDC_ADDR_PLL_CLK))
        pll_clk_r <= pll_merge(wb_data, pll_clk_r);
      if (hit(wa_en, wa_addr, `CDC_ADDR_ROUTE)) route_r <= wa_data;
      else if (hit(wb_en, addr2, `CDC_ADDR_ROUTE)) route_r <= wb_data;
    end
  end

  // ==========================================================
  // Clock routing decode
  cdc_route_decode u_decode (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pll_clk(pll_clk_r),
    .i_route(route_r),
    .i_mode_aux(mode_r[`CDC_BIT_MODE_AUX]),
    .i_full_duplex(io_cfg_r[`CDC_BIT_FULL_DUPLEX]),
    .o_route(o_route)
  );

endmodule // cdc_clock_config

//--- cdc_clock_config_tb.sv
/*
 * Testbench: serial frames in both bit orders and pin schemes, checked
 * against read data and the routing outputs.
 * Assumes the checker is bound by its own file; serial clock is slow.
 */
`timescale 1ns/100ps

module cdc_clock_config_tb;
  logic i_clk, i_nrst = 1'b0, sen_n = 1'b1, sclk = 1'b0, tb_din = 1'b0;
  logic lsb_m = 1'b0, three_w = 1'b0, o_sdio, o_sdio_oe_n, o_so, o_so_oe_n;
  logic [15:0] q;
  wire logic sdio_w;
  cdc_pkg::cdc_route_t route;
  int num_errors = 0, tests_run = 0;

  // Shared data wire: the design wins while its enable is low
  assign sdio_w = o_sdio_oe_n ? tb_din : o_sdio;
  cdc_clock_config u_cdc_clock_config (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_sen_n(sen_n), .i_sclk(sclk), .i_sdio(sdio_w), .o_sdio(o_sdio),
    .o_sdio_oe_n(o_sdio_oe_n), .o_serial_data_out(o_so),
    .o_serial_data_out_oe_n(o_so_oe_n), .o_route(route));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ==========================================================
  // Reporting
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_data(input string what, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_route(input cdc_pkg::cdc_route_t e);
    tests_run++;
    if (route !== e) begin
      num_errors++;
      $display("mismatch o_route expected %h seen %h", e, route);
    end
  endtask
  function automatic cdc_pkg::cdc_route_t mk(input logic [7:0] p, r,
                                             input logic en);
    mk.pll_bypass = p[7];
    mk.pll_mult = p[2:0];
    mk.div_five = p[3];
    mk.alt_timing = p[4];
    mk.adc_halve = p[5];
    mk.adc_src_pll = p[4];
    mk.rx_src_pll = p[4];
    mk.aux_from_pll = r[5] & en;
    mk.loop_narrow = r[2];
  endfunction

  // ==========================================================
  // Serial frame: six i_clk cycles per phase, cut > 0 aborts early
  task automatic frame(input logic rd, dual, input logic [5:0] a,
                       input logic [15:0] d, input int cut);
    logic [23:0] s;
    int n, idx;
    s = {rd, dual, a, d};
    n = (cut > 0) ? cut : (dual ? 24 : 16);
    q = 16'h0000;
    sen_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      idx = (i / 8) * 8 + (lsb_m ? 7 - (i % 8) : (i % 8));
      tb_din <= s[23 - idx];
      repeat (6) @(posedge i_clk);
      // Released split output pin reads inverted, so a missing enable shows up
      if (i >= 8) q[23 - idx] = three_w ? sdio_w :
                                (o_so_oe_n ? ~o_so : o_so);
      sclk <= 1'b1;
      repeat (6) @(posedge i_clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    sen_n <= 1'b1;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input int c);
    frame(1'b0, 1'b0, a, {d, 8'h00}, c);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    frame(1'b1, 1'b0, a, 16'h0000, 0);
    cmp_data("read byte", {8'h00, e}, {8'h00, q[15:8]});
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    logic [7:0] v;
    logic [5:0] adr [6];
    logic [7:0] rst [6];
    adr = '{6'h00, 6'h01, 6'h14, 6'h15, 6'h16, 6'h20};
    rst = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    cmp_route(mk(8'h00, 8'h00, 1'b1));
    wr(6'h20, 8'hFF, 0);
    for (int k = 0; k < 6; k++) rd_chk(adr[k], rst[k]);
    // Every legal multiplier code, alternating the other controls
    for (int m = 0; m < 5; m++) begin
      v = (m[0] ? 8'hB8 : 8'h00) | 8'(m);
      wr(6'h15, v, 0);
      cmp_route(mk(v, 8'h00, 1'b1));
    end
    wr(6'h15, 8'h2F, 0);
    cmp_route(mk(8'h2C, 8'h00, 1'b1));
    rd_chk(6'h15, 8'h2C);
    wr(6'h16, 8'h24, 0);
    cmp_route(mk(8'h2C, 8'h24, 1'b1));
    wr(6'h14, 8'h00, 0);
    cmp_route(mk(8'h2C, 8'h24, 1'b0));
    wr(6'h01, 8'h04, 0);
    cmp_route(mk(8'h2C, 8'h24, 1'b1));
    frame(1'b0, 1'b1, 6'h16, 16'h0490, 0);
    cmp_route(mk(8'h90, 8'h04, 1'b1));
    // Aborted writes leave everything as it was
    wr(6'h15, 8'h00, 15);
    frame(1'b0, 1'b1, 6'h16, 16'h0000, 23);
    cmp_route(mk(8'h90, 8'h04, 1'b1));
    wr(6'h00, 8'h40, 0);
    lsb_m = 1'b1;
    frame(1'b0, 1'b1, 6'h15, 16'h2120, 0);
    cmp_route(mk(8'h21, 8'h20, 1'b1));
    frame(1'b1, 1'b1, 6'h15, 16'h0000, 0);
    cmp_data("dual read", 16'h2120, q);
    wr(6'h00, 8'hC0, 0);
    three_w = 1'b1;
    rd_chk(6'h16, 8'h20);
    wr(6'h00, 8'h80, 0);
    lsb_m = 1'b0;
    rd_chk(6'h00, 8'h80);
    // Mid-run reset brings every register back to its default
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    three_w = 1'b0;
    repeat (3) @(posedge i_clk);
    cmp_route(mk(8'h00, 8'h00, 1'b1));
    rd_chk(6'h00, 8'h00);
    complete_run();
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge i_clk);
    num_errors++;
    complete_run();
  end
endmodule // cdc_clock_config_tb

//--- cdc_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * clock distribution configuration block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CDC_PARAMS_SVH
`define CDC_PARAMS_SVH

// ==========================================================
// Register offsets (6-bit serial address space)
`define CDC_ADDR_PORT_CFG 6'h00
`define CDC_ADDR_MODE 6'h01
`define CDC_ADDR_IO_CFG 6'h14
`define CDC_ADDR_PLL_CLK 6'h15
`define CDC_ADDR_ROUTE 6'h16

// ==========================================================
// Field positions
`define CDC_BIT_THREE_WIRE 7
`define CDC_BIT_LSB_FIRST 6
`define CDC_BIT_MODE_AUX 2
`define CDC_BIT_FULL_DUPLEX 4
`define CDC_BIT_BYPASS 7
`define CDC_BIT_ADC_HALVE 5
`define CDC_BIT_ALT_TIMING 4
`define CDC_BIT_DIV_FIVE 3
`define CDC_BIT_AUX_PLL 5
`define CDC_BIT_NARROW 2
`define CDC_MULT_MAX 3'h4

// ==========================================================
// Reset values
`define CDC_RST_PORT_CFG 8'h00
`define CDC_RST_MODE 8'h00
`define CDC_RST_IO_CFG 8'h10
`define CDC_RST_PLL_CLK 8'h00
`define CDC_RST_ROUTE 8'h00

// ==========================================================
// Serial frame counts, in rising serial clock edges
`define CDC_EDGE_INSTR 5'h07
`define CDC_EDGE_BYTE1 5'h0F
`define CDC_EDGE_BYTE2 5'h17

`endif

//--- cdc_pkg.sv
/*
 * Types of the clock distribution configuration block.
 * Assumes nothing of its surroundings.
 */
package cdc_pkg;

  // Decoded clock routing controls for the analog clock tree
  typedef struct packed {
    logic pll_bypass;
    logic [2:0] pll_mult;
    logic div_five;
    logic alt_timing;
    logic adc_halve;
    logic adc_src_pll;
    logic rx_src_pll;
    logic aux_from_pll;
    logic loop_narrow;
  } cdc_route_t;

  // Decoded instruction byte
  typedef struct packed {
    logic rd;
    logic dual;
    logic [5:0] addr;
  } cdc_instr_t;

endpackage

//--- cdc_route_decode.sv
/*
 * Turns the stored clock registers into registered routing controls.
 * Assumes register values from the same clock domain.
 */
`timescale 1ns/100ps
`include "cdc_params.svh"

module cdc_route_decode (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_pll_clk,
  input wire logic [7:0] i_route,
  input wire logic i_mode_aux,
  input wire logic i_full_duplex,
  output cdc_pkg::cdc_route_t o_route
);

  // ==========================================================
  // Decode
  wire cdc_pkg::cdc_route_t route_nxt;
  wire logic alt = i_pll_clk[`CDC_BIT_ALT_TIMING];
  wire logic aux_ok = i_mode_aux | i_full_duplex;

  // Bypass leaves PLL running, only the output path moves
  assign route_nxt.pll_bypass = i_pll_clk[`CDC_BIT_BYPASS];
  assign route_nxt.pll_mult = i_pll_clk[2:0];
  assign route_nxt.div_five = i_pll_clk[`CDC_BIT_DIV_FIVE];
  assign route_nxt.alt_timing = alt;
  assign route_nxt.adc_halve = i_pll_clk[`CDC_BIT_ADC_HALVE];
  assign route_nxt.adc_src_pll = alt;
  // Alternate timing: tx ref feeds PLL which clocks both paths
  assign route_nxt.rx_src_pll = alt;
  // Aux switch only honoured in the qualifying interface modes
  assign route_nxt.aux_from_pll = i_route[`CDC_BIT_AUX_PLL] & aux_ok;
  assign route_nxt.loop_narrow = i_route[`CDC_BIT_NARROW];

  // ==========================================================
  // Output register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_route <= '0;
    end else begin
      o_route <= route_nxt;
    end
  end

endmodule // cdc_route_decode
